// *** bench/tb.sv ***
// testbench: self-checking scenarios for the trigger evaluator
`timescale 1ns/100ps
module tb;
    import tce_pkg::*;
    // ==========================================================
    // signals and design hookup
    localparam int BITS = 8;  // loose bits
    localparam int NODES = 5; // short tree keeps the tables small
    logic clk = 1'b0;
    logic rstn = 1'b0;
    tce_mode_t mode = TCE_MODE_BASIC_OR;
    tce_pat_t [BITS-1:0] bit_pat = {BITS{TCE_PAT_DONT_CARE}};
    tce_cmp_cfg_t cmp = '0;
    tce_node_cfg_t [NODES-1:0] nodes = '0;
    logic [TCE_BUS_W-1:0] probe_bus;
    logic [BITS-1:0] probe_bits;
    logic trig;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;

    tce_partner #(.BITS_N(BITS)) pm (
        .probe_bus_o(probe_bus), .probe_bits_o(probe_bits));
    tce_trigger #(.BITS_N(BITS), .NODES_N(NODES)) dut (
        .clk_i(clk), .rstn_i(rstn), .probe_bus_i(probe_bus),
        .probe_bits_i(probe_bits), .mode_i(mode), .bit_pat_i(bit_pat),
        .cmp_cfg_i(cmp), .node_cfg_i(nodes), .trigger_o(trig));

    // ==========================================================
    // shared tasks
    // inputs move 2 ns after the edge, result read 2 ns after next
    task automatic tick();
        @(posedge clk);
        #2;
    endtask : tick

    task automatic check_bit(input string what, input logic exp,
                             input logic got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic set_node(input int i, input tce_op_t op, input int a,
                            input int b, input tce_pat_t p,
                            input logic [TCE_BUS_W-1:0] k);
        nodes[i] = '{op: op, src_a: TCE_SRC_W'(a),
                     src_b: TCE_SRC_W'(b), pat: p, konst: k};
    endtask : set_node

    // reference value of one operator node, unsigned
    function automatic logic [TCE_BUS_W-1:0] op_ref(
        input tce_op_t op, input logic [TCE_BUS_W-1:0] a, b);
        case (op)
            TCE_OP_LT: return 16'(a < b);
            TCE_OP_LE: return 16'(a <= b);
            TCE_OP_EQ: return 16'(a == b);
            TCE_OP_NE: return 16'(a != b);
            TCE_OP_GE: return 16'(a >= b);
            TCE_OP_GT: return 16'(a > b);
            TCE_OP_BNOT: return ~a;
            TCE_OP_BAND: return a & b;
            TCE_OP_BOR: return a | b;
            TCE_OP_BXOR: return a ^ b;
            TCE_OP_LNOT: return 16'(a == 0);
            TCE_OP_LAND: return 16'(a != 0 && b != 0);
            TCE_OP_LOR: return 16'(a != 0 || b != 0);
            TCE_OP_LXOR: return 16'((a != 0) ^ (b != 0));
            TCE_OP_RAND: return 16'(&a);
            TCE_OP_ROR: return 16'(|a);
            TCE_OP_RXOR: return 16'(^a);
            TCE_OP_SHL: return a << b;
            TCE_OP_SHR: return a >> b;
            default: return 16'h0000;
        endcase
    endfunction : op_ref

    // ==========================================================
    // scenarios
    // every relation against values just below, at and above
    task automatic scen_relation();
        logic e;
        mode = TCE_MODE_COMPARE;
        cmp = '0;
        cmp.value = 16'h0005;
        for (int r = 0; r < 5; r++) begin
            for (int v = 4; v < 7; v++) begin
                cmp.rel = tce_rel_t'(r);
                pm.put(16'(v), '0);
                e = (r == 0) ? v > 5 : (r == 1) ? v >= 5 :
                    (r == 2) ? v == 5 : (r == 3) ? v <= 5 : v < 5;
                tick();
                check_bit("relation", e, trig);
            end
        end
    endtask : scen_relation

    // both bounds probed under all four inclusion settings
    task automatic scen_interval();
        logic [TCE_BUS_W-1:0] pts [5] = '{16'h0009, 16'h000A,
            16'h000F, 16'h0014, 16'h0015};
        logic e;
        cmp.interval = 1'b1;
        cmp.lower = 16'h000A;
        cmp.upper = 16'h0014;
        for (int f = 0; f < 4; f++) begin
            {cmp.lower_incl, cmp.upper_incl} = 2'(f);
            foreach (pts[i]) begin
                pm.put(pts[i], '0);
                e = (pts[i] > 16'h000A || (f > 1 && pts[i] == 16'h000A))
                    && (pts[i] < 16'h0014 || (f[0] && pts[i] == 16'h0014));
                tick();
                check_bit("interval", e, trig);
            end
        end
    endtask : scen_interval

    // each bit pattern on a rise and a fall, basic and compare modes
    task automatic scen_pattern();
        logic [5:0] rise_hit = 6'h34; // high, rise, either
        logic [5:0] fall_hit = 6'h2A; // low, fall, either
        cmp = '0;
        cmp.rel = TCE_REL_EQ;
        cmp.value = 16'hFFFF; // compare never hits with bus at zero
        for (int m = 0; m < 2; m++) begin
            mode = tce_mode_t'(m);
            for (int p = 0; p < 6; p++) begin
                bit_pat[0] = tce_pat_t'(p);
                pm.put(16'h0000, 8'h00);
                tick();
                pm.put(16'h0000, 8'h01);
                tick();
                check_bit("rise", rise_hit[p], trig);
                pm.put(16'h0000, 8'h00);
                tick();
                check_bit("fall", fall_hit[p], trig);
            end
        end
        bit_pat = {BITS{TCE_PAT_DONT_CARE}};
    endtask : scen_pattern

    // each of the 19 non-leaf operators checked by an equality node against a constant
    task automatic scen_ops();
        tce_op_t ops [19] = '{TCE_OP_LT, TCE_OP_LE, TCE_OP_EQ, TCE_OP_NE,
            TCE_OP_GE, TCE_OP_GT, TCE_OP_BNOT, TCE_OP_BAND, TCE_OP_BOR,
            TCE_OP_BXOR, TCE_OP_LNOT, TCE_OP_LAND, TCE_OP_LOR, TCE_OP_LXOR,
            TCE_OP_RAND, TCE_OP_ROR, TCE_OP_RXOR, TCE_OP_SHL, TCE_OP_SHR};
        logic [TCE_BUS_W-1:0] av [3] = '{16'h00F0, 16'h0003, 16'hFFFF};
        logic [TCE_BUS_W-1:0] bv [3] = '{16'h0003, 16'h0003, 16'h0000};
        logic [TCE_BUS_W-1:0] e;
        mode = TCE_MODE_ADVANCED;
        set_node(0, TCE_OP_BUS, 0, 0, TCE_PAT_DONT_CARE, 16'h0000);
        set_node(4, TCE_OP_EQ, 3, 2, TCE_PAT_DONT_CARE, 16'h0000);
        foreach (ops[o]) begin
            foreach (av[j]) begin
                e = op_ref(ops[o], av[j], bv[j]);
                set_node(1, TCE_OP_BUSVAL, 0, 0, TCE_PAT_DONT_CARE, bv[j]);
                set_node(2, TCE_OP_BUSVAL, 0, 0, TCE_PAT_DONT_CARE, e);
                set_node(3, ops[o], 0, 1, TCE_PAT_DONT_CARE, 16'h0000);
                pm.put(av[j], '0);
                tick();
                check_bit("operator", 1'b1, trig);
                set_node(2, TCE_OP_BUSVAL, 0, 0, TCE_PAT_DONT_CARE,
                         e ^ 16'h0001);
                tick();
                check_bit("operator miss", 1'b0, trig);
            end
        end
    endtask : scen_ops

    // bus at least a constant and bit 2 rising, then bit leaves
    task automatic scen_tree();
        logic [TCE_BUS_W-1:0] bus_s [5] = '{16'h0008, 16'h0008,
            16'h0008, 16'h0008, 16'h0003};
        logic [BITS-1:0] bit_s [5] = '{8'h00, 8'h04, 8'h04, 8'h00, 8'h04};
        logic [4:0] exp_s = 5'h02; // only the second step fires
        set_node(1, TCE_OP_BUSVAL, 0, 0, TCE_PAT_DONT_CARE, 16'h0005);
        set_node(2, TCE_OP_GE, 0, 1, TCE_PAT_DONT_CARE, 16'h0000);
        set_node(3, TCE_OP_EDGE, 2, 0, TCE_PAT_RISE, 16'h0000);
        set_node(4, TCE_OP_LAND, 2, 3, TCE_PAT_DONT_CARE, 16'h0000);
        foreach (bus_s[i]) begin
            pm.put(bus_s[i], bit_s[i]);
            tick();
            check_bit("tree", exp_s[i], trig);
        end
        set_node(3, TCE_OP_BIT, 2, 0, TCE_PAT_DONT_CARE, 16'h0000);
        pm.put(16'h0008, 8'h04);
        tick();
        check_bit("bit leaf", 1'b1, trig);
        set_node(3, TCE_OP_BITVAL, 0, 0, TCE_PAT_DONT_CARE, 16'h0001);
        tick();
        check_bit("bit value leaf", 1'b1, trig);
        // an undefined mode code must hold the trigger low
        mode = tce_mode_t'(2'h3);
        tick();
        check_bit("bad mode", 1'b0, trig);
    endtask : scen_tree

    // ==========================================================
    // verdict, clock, watchdog and main sequence
    task automatic wrap_up();
        if (miscompares == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up

    initial begin
        forever #12.5 clk = ~clk;
    end

    // a hung scenario ends here as a failure
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            wrap_up();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        #2;
        check_bit("reset", 1'b0, trig);
        rstn = 1'b1;
        scen_relation();
        scen_interval();
        scen_pattern();
        scen_ops();
        scen_tree();
        wrap_up();
    end
endmodule : tb

// *** bench/tce_partner.sv ***
// partner: probed user signals feeding the trigger evaluator
`timescale 1ns/100ps
module tce_partner
    import tce_pkg::*;
#(
    parameter int BITS_N = TCE_BITS_N
) (
    // probed design signals
    output logic [TCE_BUS_W-1:0] probe_bus_o,
    output logic [BITS_N-1:0] probe_bits_o
);
    // ==========================================================
    // a quiet user design starts all low
    initial begin
        probe_bus_o = 16'h0000;
        probe_bits_o = '0;
    end

    // new sample, typed to the bus width so it cannot overflow
    task automatic put(input logic [TCE_BUS_W-1:0] bus,
                       input logic [BITS_N-1:0] bits);
        probe_bus_o = bus;
        probe_bits_o = bits;
    endtask : put
endmodule : tce_partner

// *** inc/tce_pkg.sv ***
// package: shared types and constants for the trigger evaluator
package tce_pkg;
    // ==========================================================
    // widths
    localparam int TCE_BUS_W = 16;   // probed bus width, fixed
    localparam int TCE_BITS_N = 8;   // loose probed bits default
    localparam int TCE_NODES_N = 8;  // expression tree slots default
    localparam int TCE_SRC_W = 4;    // operand select width

    // ==========================================================
    // per-bit basic pattern encodings
    typedef enum logic [2:0] {
        TCE_PAT_DONT_CARE = 3'h0,
        TCE_PAT_LOW = 3'h1,
        TCE_PAT_HIGH = 3'h2,
        TCE_PAT_FALL = 3'h3,
        TCE_PAT_RISE = 3'h4,
        TCE_PAT_EITHER = 3'h5
    } tce_pat_t;

    // single-value relations
    typedef enum logic [2:0] {
        TCE_REL_GT = 3'h0,
        TCE_REL_GE = 3'h1,
        TCE_REL_EQ = 3'h2,
        TCE_REL_LE = 3'h3,
        TCE_REL_LT = 3'h4
    } tce_rel_t;

    // trigger evaluation mode
    typedef enum logic [1:0] {
        TCE_MODE_BASIC_OR = 2'h0,
        TCE_MODE_COMPARE = 2'h1,
        TCE_MODE_ADVANCED = 2'h2
    } tce_mode_t;

    // expression node operators
    typedef enum logic [4:0] {
        TCE_OP_BIT, TCE_OP_BITVAL, TCE_OP_BUS, TCE_OP_BUSVAL,
        TCE_OP_EDGE,
        TCE_OP_LT, TCE_OP_LE, TCE_OP_EQ, TCE_OP_NE, TCE_OP_GE,
        TCE_OP_GT,
        TCE_OP_BNOT, TCE_OP_BAND, TCE_OP_BOR, TCE_OP_BXOR,
        TCE_OP_LNOT, TCE_OP_LAND, TCE_OP_LOR, TCE_OP_LXOR,
        TCE_OP_RAND, TCE_OP_ROR, TCE_OP_RXOR,
        TCE_OP_SHL, TCE_OP_SHR
    } tce_op_t;

    // comparison trigger settings
    typedef struct packed {
        logic interval;              // 1 = interval check
        tce_rel_t rel;               // relation for single value
        logic [TCE_BUS_W-1:0] value; // single value operand
        logic [TCE_BUS_W-1:0] lower; // interval lower bound
        logic [TCE_BUS_W-1:0] upper; // interval upper bound
        logic lower_incl;            // lower bound counts inside
        logic upper_incl;            // upper bound counts inside
    } tce_cmp_cfg_t;

    // one expression node
    typedef struct packed {
        tce_op_t op;                 // operator
        logic [TCE_SRC_W-1:0] src_a; // first operand slot / bit
        logic [TCE_SRC_W-1:0] src_b; // second operand slot
        tce_pat_t pat;               // edge/level pattern
        logic [TCE_BUS_W-1:0] konst; // constant value
    } tce_node_cfg_t;
endpackage : tce_pkg

// *** logic/tce_bit_match.sv ***
// module: per-bit level and edge pattern matcher
`timescale 1ns/100ps
module tce_bit_match
    import tce_pkg::*;
(
    // sample pair
    input wire logic cur_i,
    input wire logic prev_i,
    // pattern
    input wire tce_pat_t pat_i,
    // result
    output logic match_o
);
    // ==========================================================
    // match decode
    // either-edge is any difference from the last sample
    always_comb begin
        case (pat_i)
            TCE_PAT_DONT_CARE: match_o = 1'b1;
            TCE_PAT_LOW: match_o = ~cur_i;
            TCE_PAT_HIGH: match_o = cur_i;
            TCE_PAT_FALL: match_o = prev_i & ~cur_i;
            TCE_PAT_RISE: match_o = ~prev_i & cur_i;
            TCE_PAT_EITHER: match_o = prev_i ^ cur_i;
            default: match_o = 1'b0;
        endcase
    end
endmodule : tce_bit_match

// *** logic/tce_trigger.sv ***
// module: comparison and expression trigger evaluator
// ==============================================================
`timescale 1ns/100ps
module tce_trigger
    import tce_pkg::*;
#(
    parameter int BITS_N = TCE_BITS_N,
    parameter int NODES_N = TCE_NODES_N
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // probed signals
    input wire logic [TCE_BUS_W-1:0] probe_bus_i,
    input wire logic [BITS_N-1:0] probe_bits_i,
    // run-time configuration
    input wire tce_mode_t mode_i,
    input wire tce_pat_t [BITS_N-1:0] bit_pat_i,
    input wire tce_cmp_cfg_t cmp_cfg_i,
    input wire tce_node_cfg_t [NODES_N-1:0] node_cfg_i,
    // result
    output logic trigger_o
);
    // ==========================================================
    // elaboration checks
    // operand selects must reach every slot and bit
    initial begin
        if (NODES_N < 1 || NODES_N > (1 << TCE_SRC_W) ||
            BITS_N < 1 || BITS_N > (1 << TCE_SRC_W))
            $error("tce_trigger: unsupported size parameters");
    end

    // ==========================================================
    // sample history
    logic [TCE_BUS_W-1:0] prev_bus; // last cycle bus sample
    logic [BITS_N-1:0] prev_bits;   // last cycle bit samples

    // previous samples for edge detection
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prev_bus <= '0;
            prev_bits <= '0;
        end else begin
            prev_bus <= probe_bus_i;
            prev_bits <= probe_bits_i;
        end
    end

    // ==========================================================
    // basic per-bit patterns
    logic [BITS_N-1:0] bit_ok; // per-bit match
    logic [BITS_N-1:0] bit_care; // bit not dont-care

    genvar gi;
    generate
        for (gi = 0; gi < BITS_N; gi++) begin : g_bits
            tce_bit_match u_match (
                .cur_i(probe_bits_i[gi]),
                .prev_i(prev_bits[gi]),
                .pat_i(bit_pat_i[gi]),
                .match_o(bit_ok[gi])
            );
            assign bit_care[gi] = (bit_pat_i[gi] != TCE_PAT_DONT_CARE);
        end
    endgenerate

    // or of cared bits; all dont-care leaves it false
    logic basic_hit;
    assign basic_hit = |(bit_ok & bit_care);

    // ==========================================================
    // comparison trigger
    logic single_hit; // single value relation holds
    logic lo_ok;      // above lower bound
    logic hi_ok;      // below upper bound
    logic cmp_hit;    // selected comparison result

    // relation on the unsigned bus value
    always_comb begin
        case (cmp_cfg_i.rel)
            TCE_REL_GT: single_hit = probe_bus_i > cmp_cfg_i.value;
            TCE_REL_GE: single_hit = probe_bus_i >= cmp_cfg_i.value;
            TCE_REL_EQ: single_hit = probe_bus_i == cmp_cfg_i.value;
            TCE_REL_LE: single_hit = probe_bus_i <= cmp_cfg_i.value;
            TCE_REL_LT: single_hit = probe_bus_i < cmp_cfg_i.value;
            default: single_hit = 1'b0;
        endcase
    end

    // each bound has its own inclusion choice
    assign lo_ok = cmp_cfg_i.lower_incl ?
        (probe_bus_i >= cmp_cfg_i.lower) :
        (probe_bus_i > cmp_cfg_i.lower);
    assign hi_ok = cmp_cfg_i.upper_incl ?
        (probe_bus_i <= cmp_cfg_i.upper) :
        (probe_bus_i < cmp_cfg_i.upper);
    assign cmp_hit = cmp_cfg_i.interval ? (lo_ok & hi_ok) :
        single_hit;

    // ==========================================================
    // expression tree
    // node k reads only lower slots, so the chain is acyclic
    logic [TCE_BUS_W-1:0] node_val [NODES_N]; // node outputs

    generate
        for (gi = 0; gi < NODES_N; gi++) begin : g_node
            logic [TCE_BUS_W-1:0] a; // operand a
            logic [TCE_BUS_W-1:0] b; // operand b
            logic ab; // probed bit at src_a
            logic pb; // previous of that bit
            logic [TCE_BUS_W-1:0] r;

            // operands; a forward or self reference reads zero
            always_comb begin
                a = '0;
                b = '0;
                for (int j = 0; j < gi; j++) begin
                    if (node_cfg_i[gi].src_a == TCE_SRC_W'(j))
                        a = node_val[j];
                    if (node_cfg_i[gi].src_b == TCE_SRC_W'(j))
                        b = node_val[j];
                end
            end

            // bit leaf selection, out of range reads low
            always_comb begin
                ab = 1'b0;
                pb = 1'b0;
                for (int j = 0; j < BITS_N; j++) begin
                    if (node_cfg_i[gi].src_a == TCE_SRC_W'(j)) begin
                        ab = probe_bits_i[j];
                        pb = prev_bits[j];
                    end
                end
            end

            logic edge_ok; // edge and level detector output
            tce_bit_match u_edge (
                .cur_i(ab),
                .prev_i(pb),
                .pat_i(node_cfg_i[gi].pat),
                .match_o(edge_ok)
            );

            // operator decode; one-bit results sit in bit 0
            always_comb begin
                r = '0;
                case (node_cfg_i[gi].op)
                    TCE_OP_BIT: r[0] = ab;
                    TCE_OP_BITVAL: r[0] = node_cfg_i[gi].konst[0];
                    TCE_OP_BUS: r = probe_bus_i;
                    TCE_OP_BUSVAL: r = node_cfg_i[gi].konst;
                    TCE_OP_EDGE: r[0] = edge_ok;
                    TCE_OP_LT: r[0] = a < b;
                    TCE_OP_LE: r[0] = a <= b;
                    TCE_OP_EQ: r[0] = a == b;
                    TCE_OP_NE: r[0] = a != b;
                    TCE_OP_GE: r[0] = a >= b;
                    TCE_OP_GT: r[0] = a > b;
                    TCE_OP_BNOT: r = ~a;
                    TCE_OP_BAND: r = a & b;
                    TCE_OP_BOR: r = a | b;
                    TCE_OP_BXOR: r = a ^ b;
                    TCE_OP_LNOT: r[0] = ~(|a);
                    TCE_OP_LAND: r[0] = (|a) & (|b);
                    TCE_OP_LOR: r[0] = (|a) | (|b);
                    TCE_OP_LXOR: r[0] = (|a) ^ (|b);
                    TCE_OP_RAND: r[0] = &a;
                    TCE_OP_ROR: r[0] = |a;
                    TCE_OP_RXOR: r[0] = ^a;
                    TCE_OP_SHL: r = a << b;
                    TCE_OP_SHR: r = a >> b;
                    default: r = '0;
                endcase
            end
            assign node_val[gi] = r;
        end
    endgenerate

    // top slot is the tree root
    logic adv_hit;
    assign adv_hit = |node_val[NODES_N-1];

    // ==========================================================
    // mode select and registered result
    logic next_trigger;

    // mode taken live each cycle, no rebuild needed
    always_comb begin
        case (mode_i)
            TCE_MODE_BASIC_OR: next_trigger = basic_hit;
            TCE_MODE_COMPARE: next_trigger = cmp_hit | basic_hit;
            TCE_MODE_ADVANCED: next_trigger = adv_hit;
            default: next_trigger = 1'b0;
        endcase
    end

    // trigger register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i)
            trigger_o <= 1'b0;
        else
            trigger_o <= next_trigger;
    end

    // ==========================================================
    // assertions
    // the lag check waits one edge after reset, whose register was forced
    trig_lag_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        $past(rstn_i) |-> trigger_o == $past(next_trigger))
        else $error("trigger not one cycle after condition");
    single_eq_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (mode_i == TCE_MODE_COMPARE && !cmp_cfg_i.interval &&
         cmp_cfg_i.rel == TCE_REL_EQ && probe_bus_i == cmp_cfg_i.value)
        |=> trigger_o)
        else $error("equal compare missed");
    interval_in_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (mode_i == TCE_MODE_COMPARE && cmp_cfg_i.interval &&
         probe_bus_i > cmp_cfg_i.lower && probe_bus_i < cmp_cfg_i.upper)
        |=> trigger_o)
        else $error("inside interval missed");
    lower_excl_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (cmp_cfg_i.interval && !cmp_cfg_i.lower_incl &&
         probe_bus_i == cmp_cfg_i.lower) |-> !cmp_hit)
        else $error("excluded lower bound counted inside");
    upper_incl_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (cmp_cfg_i.interval && cmp_cfg_i.upper_incl &&
         cmp_cfg_i.lower < cmp_cfg_i.upper &&
         probe_bus_i == cmp_cfg_i.upper) |-> cmp_hit)
        else $error("included upper bound counted outside");
    basic_keep_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (mode_i == TCE_MODE_COMPARE && basic_hit) |=> trigger_o)
        else $error("basic pattern lost in compare mode");
    rise_edge_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (mode_i == TCE_MODE_BASIC_OR && bit_pat_i[0] == TCE_PAT_RISE &&
         $rose(probe_bits_i[0])) |=> trigger_o)
        else $error("rising edge pattern missed");
    dont_care_a: assert property (
        @(posedge clk_i) disable iff (!rstn_i)
        (mode_i == TCE_MODE_BASIC_OR && bit_care == '0) |=> !trigger_o)
        else $error("all dont-care bits fired trigger");
endmodule : tce_trigger
